// file: src/smcp_pkg.sv
// constants, types and check-bit functions of the supply modulated config port
package smcp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // word layout
    localparam int DATA_W = 16;
    localparam int FRAME_BITS = 17;
    localparam int ECC_W = 6;
    localparam int LINE_W = 22;
    localparam int CNT_W = 16;
    localparam int STOP_CNT_W = 24;

    // line addresses
    localparam logic [0:0] ADDR_LINE0 = 1'h0;
    localparam logic [0:0] ADDR_LINE1 = 1'h1;

    // line 0 fields
    localparam int L0_ZERO_BIT = 15;
    localparam int L0_HIGH_SPEED_BIT = 13;
    localparam int L0_STAND_EN_BIT = 11;
    // line 1 fields
    localparam int L1_SEL_LSB = 12;
    localparam int L1_DIR_INV_BIT = 11;
    localparam int L1_DIR_EN_BIT = 2;
    localparam int L1_LOCK_BIT = 0;
    localparam logic [1:0] SEL_STAND_OK = 2'h0;

    // stored values after power-on
    localparam logic [15:0] LINE0_RESET = 16'h0000;
    localparam logic [15:0] LINE1_RESET = 16'h73A6;

    // command word: op in the top two bits, line address in bit 0
    localparam int OP_LSB = 14;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [15:0] ENTRY_CMD = 16'hA5C3;

    ////////////////////////////////////////////////////////////////////////////
    // timing of the link clock domain
    localparam int LINK_CLK_PERIOD_NS = 48;
    localparam int STOP_TOTAL_MS = 750;
    localparam int STOP_HIGH_MS = 30;
    localparam int STOP_LOW_NS = (STOP_TOTAL_MS - STOP_HIGH_MS) * 1000000;
    localparam int STOP_LOW_CYC = (STOP_LOW_NS + LINK_CLK_PERIOD_NS - 1) / LINK_CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        ST_ENTRY = 4'b0001,
        ST_CMD = 4'b0010,
        ST_WDATA = 4'b0100,
        ST_OFF = 4'b1000
    } smcp_state_e;

    ////////////////////////////////////////////////////////////////////////////
    // hamming code over 21 positions plus overall parity in the top bit
    function automatic logic [5:0] smcp_ecc_check(input logic [15:0] d);
        logic [5:0] c;
        int k;
        c = 6'h00;
        k = 0;
        for (int p = 3; p < 22; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (d[k]) begin
                    c[4:0] = c[4:0] ^ 5'(p);
                end
                k++;
            end
        end
        c[5] = ^{d, c[4:0]};
        return c;
    endfunction

    // returns {uncorrectable, corrected, data}
    function automatic logic [17:0] smcp_ecc_fix(input logic [21:0] w);
        logic [15:0] d;
        logic [4:0] syn;
        logic [5:0] chk;
        logic par;
        int k;
        d = w[15:0];
        chk = smcp_ecc_check(w[15:0]);
        syn = chk[4:0] ^ w[20:16];
        par = ^w;
        k = 0;
        for (int p = 3; p < 22; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (par && (5'(p) == syn)) begin
                    d[k] = ~d[k];
                end
                k++;
            end
        end
        return {(syn != 5'h00) && !par, par, d};
    endfunction

    localparam logic [21:0] LINE0_STORED = {smcp_ecc_check(LINE0_RESET), LINE0_RESET};
    localparam logic [21:0] LINE1_STORED = {smcp_ecc_check(LINE1_RESET), LINE1_RESET};

endpackage

// file: src/smcp_cfg_if.sv
// link between the port logic and the configuration line store
`timescale 1ns/1ns
interface smcp_cfg_if;
    logic wr_en;
    logic [0:0] wr_addr;
    logic [15:0] wr_data;
    logic [15:0] line0;
    logic [15:0] line1;
    logic ecc_fixed;
    logic ecc_fail;

    modport mem (input wr_en, wr_addr, wr_data, output line0, line1, ecc_fixed, ecc_fail);
    modport user (output wr_en, wr_addr, wr_data, input line0, line1, ecc_fixed, ecc_fail);
endinterface

// file: src/smcp_cfg_mem.sv
// two configuration lines with check bits, corrected read data out of registers
`timescale 1ns/1ns
module smcp_cfg_mem
    import smcp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // user side
    smcp_cfg_if.mem cfg
);

    logic [21:0] store [2];
    logic [17:0] fix0;
    logic [17:0] fix1;

    always_comb begin
        fix0 = smcp_ecc_fix(store[0]);
        fix1 = smcp_ecc_fix(store[1]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // each line keeps 16 data bits and 6 check bits
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            store[0] <= LINE0_STORED;
            store[1] <= LINE1_STORED;
        end else if (cfg.wr_en) begin
            store[cfg.wr_addr] <= {smcp_ecc_check(cfg.wr_data), cfg.wr_data};
        end
    end

    // reads always see corrected data; a double error is only flagged
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg.line0 <= LINE0_RESET;
            cfg.line1 <= LINE1_RESET;
            cfg.ecc_fixed <= 1'b0;
            cfg.ecc_fail <= 1'b0;
        end else begin
            cfg.line0 <= fix0[15:0];
            cfg.line1 <= fix1[15:0];
            cfg.ecc_fixed <= fix0[16] | fix1[16];
            cfg.ecc_fail <= fix0[17] | fix1[17];
        end
    end

endmodule // smcp_cfg_mem

// file: src/smcp_config_port.sv
// supply modulated configuration port with its two configuration lines
`timescale 1ns/1ns
module smcp_config_port
    import smcp_pkg::*;
#(
    parameter int STOP_LOW_CYCLES = STOP_LOW_CYC
) (
    // core clock and reset
    input wire logic clk,
    input wire logic nrst,
    // link clock
    input wire logic link_clk,
    // supply comparators
    input wire logic above_supply_upper_level,
    input wire logic below_supply_lower_level,
    // open-drain output pin
    output logic q_o,
    output logic q_oe,
    // configuration towards the sensing path
    output logic high_speed_mode,
    output logic stand_still_pulse_en,
    output logic [1:0] pulse_protocol_select,
    output logic direction_invert,
    output logic direction_detect_en,
    output logic user_area_locked,
    // port status
    output logic port_active,
    output logic ecc_corrected,
    output logic ecc_failure
);

    localparam logic [STOP_CNT_W-1:0] STOP_LIM = STOP_CNT_W'(STOP_LOW_CYCLES);

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        return (v == {CNT_W{1'b1}}) ? v : v + 16'h0001;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // link domain: supply comparators, three stages, change taken on agreement
    logic [2:0] hi_sync;
    logic [2:0] lo_sync;
    logic hi_lvl;
    logic lo_lvl;
    logic hi_prev;
    logic rise;

    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            hi_sync <= 3'h0;
            lo_sync <= 3'h0;
            hi_lvl <= 1'b0;
            lo_lvl <= 1'b0;
            hi_prev <= 1'b0;
        end else begin
            hi_sync <= {hi_sync[1:0], above_supply_upper_level};
            lo_sync <= {lo_sync[1:0], below_supply_lower_level};
            if (hi_sync[1] == hi_sync[2]) begin
                hi_lvl <= hi_sync[2];
            end
            if (lo_sync[1] == lo_sync[2]) begin
                lo_lvl <= lo_sync[2];
            end
            hi_prev <= hi_lvl;
        end
    end

    // each pulse starts on the rising supply edge; no other bit clock exists
    assign rise = hi_lvl & ~hi_prev;

    ////////////////////////////////////////////////////////////////////////////
    // pulse timing: high time against period, counted on the link clock
    logic [CNT_W-1:0] hi_cnt;
    logic [CNT_W-1:0] per_cnt;
    logic rx_bit;

    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            hi_cnt <= 16'h0000;
            per_cnt <= 16'h0000;
        end else if (rise) begin
            hi_cnt <= 16'h0001;
            per_cnt <= 16'h0001;
        end else begin
            per_cnt <= sat_inc(per_cnt);
            if (hi_lvl) begin
                hi_cnt <= sat_inc(hi_cnt);
            end
        end
    end

    // 2/3 and 1/3 duty sit on either side of half, leaving a wide margin
    assign rx_bit = {hi_cnt, 1'b0} > {1'b0, per_cnt};

    // stop interval: low time after the 30 ms high marker
    logic [STOP_CNT_W-1:0] lo_cnt;
    logic eow;

    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            lo_cnt <= 24'h000000;
        end else if (!lo_lvl) begin
            lo_cnt <= 24'h000000;
        end else if (lo_cnt != STOP_LIM) begin
            lo_cnt <= lo_cnt + 24'h000001;
        end
    end

    assign eow = lo_lvl && (lo_cnt == STOP_LIM - 24'h000001);

    ////////////////////////////////////////////////////////////////////////////
    // receive shifter: a pulse is decoded when the next one starts, so the
    // marker pulse before the stop interval is never shifted in
    logic [FRAME_BITS-1:0] rx_sr;
    logic [4:0] rx_cnt;
    logic pend;
    logic [15:0] rx_word;
    logic rx_tgl;

    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            rx_sr <= 17'h00000;
            rx_cnt <= 5'h00;
            pend <= 1'b0;
            rx_word <= 16'h0000;
            rx_tgl <= 1'b0;
        end else if (rise) begin
            pend <= 1'b1;
            if (pend) begin
                rx_sr <= {rx_sr[15:0], rx_bit};
                if (rx_cnt != 5'(FRAME_BITS)) begin
                    rx_cnt <= rx_cnt + 5'h01;
                end
            end
        end else if (eow) begin
            pend <= 1'b0;
            rx_cnt <= 5'h00;
            if (rx_cnt == 5'(FRAME_BITS)) begin
                rx_word <= rx_sr[16:1];
                rx_tgl <= ~rx_tgl;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit shifter: read data arrive from the core as a held word + toggle
    logic [2:0] tx_sync;
    logic tx_acc;
    logic [15:0] tx_data;
    logic tx_tgl;
    logic [15:0] tx_sr;
    logic [4:0] tx_cnt;

    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            tx_sync <= 3'h0;
            tx_acc <= 1'b0;
            tx_sr <= 16'h0000;
            tx_cnt <= 5'h10;
            q_oe <= 1'b0;
            q_o <= 1'b0;
        end else begin
            tx_sync <= {tx_sync[1:0], tx_tgl};
            q_o <= 1'b0;
            if ((tx_sync[1] == tx_sync[2]) && (tx_sync[2] != tx_acc)) begin
                tx_acc <= tx_sync[2];
                tx_sr <= tx_data;
                tx_cnt <= 5'h00;
            end else if (rise) begin
                if (tx_cnt != 5'h10) begin
                    q_oe <= ~tx_sr[15];
                    tx_sr <= {tx_sr[14:0], 1'b0};
                    tx_cnt <= tx_cnt + 5'h01;
                end else begin
                    q_oe <= 1'b0;
                end
            end else if (eow) begin
                q_oe <= 1'b0;
                tx_cnt <= 5'h10;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core domain: word toggle from the link, three stages
    logic [2:0] rx_sync;
    logic rx_acc;
    logic word_evt;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_sync <= 3'h0;
            rx_acc <= 1'b0;
        end else begin
            rx_sync <= {rx_sync[1:0], rx_tgl};
            if (word_evt) begin
                rx_acc <= rx_sync[2];
            end
        end
    end

    // rx_word was settled long before its toggle arrives here
    assign word_evt = (rx_sync[1] == rx_sync[2]) && (rx_sync[2] != rx_acc);

    ////////////////////////////////////////////////////////////////////////////
    // command handling
    smcp_cfg_if cfg ();
    smcp_state_e state;
    logic [0:0] wr_sel;
    logic [15:0] rd_line;

    function automatic logic [15:0] wr_sel_read(input logic a, input logic [15:0] l0,
                                                input logic [15:0] l1);
        logic [15:0] v;
        v = l0;
        v[L0_ZERO_BIT] = 1'b0;
        return a ? l1 : v;
    endfunction

    assign rd_line = wr_sel_read(rx_word[0], cfg.line0, cfg.line1);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_ENTRY;
            wr_sel <= 1'h0;
            cfg.wr_en <= 1'b0;
            cfg.wr_addr <= 1'h0;
            cfg.wr_data <= 16'h0000;
            tx_data <= 16'h0000;
            tx_tgl <= 1'b0;
            port_active <= 1'b0;
        end else begin
            cfg.wr_en <= 1'b0;
            port_active <= (state == ST_CMD) || (state == ST_WDATA);
            if (word_evt) begin
                case (state)
                    ST_ENTRY: begin
                        // only the very first word may open the port
                        state <= (rx_word == ENTRY_CMD) ? ST_CMD : ST_OFF;
                    end
                    ST_CMD: begin
                        if (rx_word[15:OP_LSB] == OP_READ) begin
                            tx_data <= rd_line;
                            tx_tgl <= ~tx_tgl;
                        end else if (rx_word[15:OP_LSB] == OP_WRITE) begin
                            wr_sel <= rx_word[0];
                            state <= ST_WDATA;
                        end
                    end
                    ST_WDATA: begin
                        state <= ST_CMD;
                        // a locked store refuses every write, the lock bit too
                        if (!cfg.line1[L1_LOCK_BIT]) begin
                            cfg.wr_en <= 1'b1;
                            cfg.wr_addr <= wr_sel;
                            cfg.wr_data <= rx_word;
                            if (wr_sel == ADDR_LINE0) begin
                                cfg.wr_data[L0_ZERO_BIT] <= 1'b0;
                            end
                        end
                    end
                    ST_OFF: begin
                        state <= ST_OFF;
                    end
                    default: begin
                        state <= ST_OFF;
                    end
                endcase
            end
        end
    end

    smcp_cfg_mem u_mem (
        .clk(clk),
        .nrst(nrst),
        .cfg(cfg.mem)
    );

    ////////////////////////////////////////////////////////////////////////////
    // configuration outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            high_speed_mode <= LINE0_RESET[L0_HIGH_SPEED_BIT];
            stand_still_pulse_en <= 1'b0;
            pulse_protocol_select <= LINE1_RESET[L1_SEL_LSB +: 2];
            direction_invert <= LINE1_RESET[L1_DIR_INV_BIT];
            direction_detect_en <= LINE1_RESET[L1_DIR_EN_BIT];
            user_area_locked <= LINE1_RESET[L1_LOCK_BIT];
            ecc_corrected <= 1'b0;
            ecc_failure <= 1'b0;
        end else begin
            high_speed_mode <= cfg.line0[L0_HIGH_SPEED_BIT];
            stand_still_pulse_en <= cfg.line0[L0_STAND_EN_BIT]
                && (cfg.line1[L1_SEL_LSB +: 2] == SEL_STAND_OK);
            pulse_protocol_select <= cfg.line1[L1_SEL_LSB +: 2];
            direction_invert <= cfg.line1[L1_DIR_INV_BIT];
            direction_detect_en <= cfg.line1[L1_DIR_EN_BIT];
            user_area_locked <= cfg.line1[L1_LOCK_BIT];
            ecc_corrected <= cfg.ecc_fixed;
            ecc_failure <= cfg.ecc_fail;
        end
    end

endmodule // smcp_config_port

// file: verification/smcp_config_port_chk.sv
// port assertions of the supply modulated config port
`timescale 1ns/1ns
module smcp_config_port_chk
    import smcp_pkg::*;
#(
    parameter int STOP_LOW_CYCLES = STOP_LOW_CYC
) (
    // clocks and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic link_clk,
    // supply comparators
    input wire logic above_supply_upper_level,
    input wire logic below_supply_lower_level,
    // open-drain pin
    input wire logic q_o,
    input wire logic q_oe,
    // configuration and status
    input wire logic high_speed_mode,
    input wire logic stand_still_pulse_en,
    input wire logic [1:0] pulse_protocol_select,
    input wire logic direction_invert,
    input wire logic direction_detect_en,
    input wire logic user_area_locked,
    input wire logic port_active,
    input wire logic ecc_corrected,
    input wire logic ecc_failure
);
    logic [5:0] cfg;
    assign cfg = {high_speed_mode, stand_still_pulse_en, pulse_protocol_select,
        direction_invert, direction_detect_en};

    ////////////////////////////////////////////////////////////////////////////
    // three link cycles back the supply must already be in the pulse
    sequence s_pulse_held;
        $past(above_supply_upper_level, 3);
    endsequence

    a_reply_on_pulse: assert property (
        @(posedge link_clk) disable iff (!nrst) $rose(q_oe) |-> s_pulse_held)
        else $error("reply bit started outside a supply pulse");
    a_drain_only: assert property (
        @(posedge link_clk) disable iff (!nrst) q_oe |-> !q_o)
        else $error("pin driven high instead of released");
    a_released_at_stop: assert property (
        @(posedge link_clk) disable iff (!nrst) $rose(below_supply_lower_level) |-> !q_oe [*3])
        else $error("reply still driven in the stop interval");
    a_stand_needs_sel: assert property (
        @(posedge clk) disable iff (!nrst) stand_still_pulse_en
        |-> pulse_protocol_select == SEL_STAND_OK)
        else $error("stand-still pulse enabled with wrong protocol");
    a_active_sticky: assert property (
        @(posedge clk) disable iff (!nrst) port_active |=> port_active)
        else $error("port closed without reset");
    a_silent_idle: assert property (
        @(posedge clk) disable iff (!nrst) !port_active |-> !q_oe)
        else $error("pin driven while port closed");
    a_quiet_before_entry: assert property (
        @(posedge clk) disable iff (!nrst) !port_active |=> $stable(cfg))
        else $error("configuration changed while port closed");
    a_lock_freeze: assert property (
        @(posedge clk) disable iff (!nrst) user_area_locked |=> $stable({cfg, user_area_locked}))
        else $error("configuration changed while locked");
    a_reset_defaults: assert property (
        @(posedge clk) disable iff (!nrst) $rose(nrst) |-> pulse_protocol_select == 2'h3
        && direction_detect_en && !user_area_locked && !port_active)
        else $error("wrong values after reset");
    a_ecc_clean: assert property (
        @(posedge clk) disable iff (!nrst) !ecc_failure && !ecc_corrected)
        else $error("check bits flagged an error on clean lines");
endmodule // smcp_config_port_chk

bind smcp_config_port smcp_config_port_chk #(.STOP_LOW_CYCLES(STOP_LOW_CYCLES)) u_chk (
    .clk(clk), .nrst(nrst), .link_clk(link_clk),
    .above_supply_upper_level(above_supply_upper_level),
    .below_supply_lower_level(below_supply_lower_level),
    .q_o(q_o), .q_oe(q_oe), .high_speed_mode(high_speed_mode),
    .stand_still_pulse_en(stand_still_pulse_en), .pulse_protocol_select(pulse_protocol_select),
    .direction_invert(direction_invert), .direction_detect_en(direction_detect_en),
    .user_area_locked(user_area_locked), .port_active(port_active),
    .ecc_corrected(ecc_corrected), .ecc_failure(ecc_failure)
);

// file: verification/smcp_prog_model.sv
// programmer model: supply pulses out, open-drain reply in
`timescale 1ns/1ns
module smcp_prog_model
    import smcp_pkg::*;
#(
    parameter int BIT_CYC = 18,
    parameter int STOP_CYC = 50
) (
    // link clock
    input wire logic link_clk,
    // supply comparators
    output logic above_supply_upper_level,
    output logic below_supply_lower_level,
    // open-drain pin
    input wire logic q_o,
    input wire logic q_oe,
    // reply of the last word
    output logic [15:0] reply
);
    logic pin;
    // pull-up gives a one whenever the device lets go
    assign pin = q_oe ? q_o : 1'b1;

    initial begin
        above_supply_upper_level = 1'b0;
        below_supply_lower_level = 1'b0;
        reply = 16'h0000;
    end

    task automatic hold(input logic hi, input logic lo, input int n);
        above_supply_upper_level <= hi;
        below_supply_lower_level <= lo;
        repeat (n) @(posedge link_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // bit period far shorter than a real programmer's so the run stays short
    task automatic send_bits(input logic [31:0] bits, input int n);
        int hi;
        int j;
        @(posedge link_clk);
        for (int i = n - 1; i >= 0; i--) begin
            j = n - 1 - i;
            hi = bits[i] ? (BIT_CYC * 2) / 3 : BIT_CYC / 3;
            hold(1'b1, 1'b0, hi);
            hold(1'b0, 1'b0, BIT_CYC - hi - 1);
            // sampled late in the bit period, after the supply pulse, where the reply bit has settled
            if (j < 16) begin
                reply[15 - j] = pin;
            end
            hold(1'b0, 1'b0, 1);
        end
        hold(1'b1, 1'b0, BIT_CYC);
        hold(1'b0, 1'b1, STOP_CYC);
        hold(1'b0, 1'b0, 20);
    endtask

    task automatic send_word(input logic [15:0] w);
        send_bits({15'h0000, w, 1'b0}, 17);
    endtask
endmodule // smcp_prog_model

// file: verification/smcp_config_port_test.sv
// self-checking bench of the supply modulated config port
`timescale 1ns/1ns
module smcp_config_port_test
    import smcp_pkg::*;
;
    // cfg field order: high speed, stand-still, select, invert, direction enable
    typedef struct {
        logic [0:0] addr;
        logic [15:0] data;
        logic [15:0] rb;
        logic [5:0] cfg;
    } smcp_row_s;

    localparam int STOP_LOW = 40;
    logic clk = 1'b0;
    logic link_clk;
    logic nrst;
    logic above;
    logic below;
    logic q_o;
    logic q_oe;
    logic hs, stand, inv, den, locked, active, ecc_fix, ecc_bad;
    logic [1:0] sel;
    logic [5:0] cfg;
    int err_total;
    int checks_done;
    smcp_row_s rows [6] = '{'{1'h0, 16'hA800, 16'h2800, 6'h2D}, '{1'h1, 16'h4804, 16'h4804, 6'h33},
        '{1'h1, 16'h5000, 16'h5000, 6'h24}, '{1'h1, 16'h6804, 16'h6804, 6'h2B},
        '{1'h0, 16'h0800, 16'h0800, 6'h0B}, '{1'h1, 16'h0000, 16'h0000, 6'h10}};

    assign cfg = {hs, stand, sel, inv, den};
    always #5 clk = ~clk;
    initial begin
        link_clk = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end

    smcp_config_port #(.STOP_LOW_CYCLES(STOP_LOW)) dut (
        .clk(clk), .nrst(nrst), .link_clk(link_clk),
        .above_supply_upper_level(above), .below_supply_lower_level(below),
        .q_o(q_o), .q_oe(q_oe), .high_speed_mode(hs), .stand_still_pulse_en(stand),
        .pulse_protocol_select(sel), .direction_invert(inv), .direction_detect_en(den),
        .user_area_locked(locked), .port_active(active),
        .ecc_corrected(ecc_fix), .ecc_failure(ecc_bad)
    );

    smcp_prog_model #(.STOP_CYC(STOP_LOW + 10)) prog (
        .link_clk(link_clk), .above_supply_upper_level(above),
        .below_supply_lower_level(below), .q_o(q_o), .q_oe(q_oe), .reply()
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic do_reset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (20) @(posedge clk);
    endtask

    task automatic wr(input logic [0:0] a, input logic [15:0] d);
        prog.send_word({OP_WRITE, 13'h0000, a});
        prog.send_word(d);
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #900000;
        err_total++;
        wrap_up();
    end

    initial begin
        nrst = 1'b0;
        err_total = 0;
        checks_done = 0;
        do_reset();
        prog.send_word(ENTRY_CMD);
        check("active", {15'h0000, active}, 16'h0001);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].data);
            check("config", {10'h000, cfg}, {10'h000, rows[i].cfg});
            prog.send_word({OP_READ, 13'h0000, rows[i].addr});
            prog.send_word(16'h0000);
            check("reply", prog.reply, rows[i].rb);
        end
        // overlong word: the three leading junk bits must drop out
        prog.send_word({OP_WRITE, 13'h0000, ADDR_LINE1});
        prog.send_bits({12'h000, 3'h7, 16'h2000, 1'b0}, 20);
        check("overlong", {10'h000, cfg}, 16'h0008);
        do_reset();
        check("reset cfg", {8'h00, locked, active, cfg}, 16'h000D);
        prog.send_word(16'h1234);
        prog.send_word(ENTRY_CMD);
        check("refused", {15'h0000, active}, 16'h0000);
        do_reset();
        prog.send_word(ENTRY_CMD);
        wr(ADDR_LINE1, 16'h73A7);
        check("lock", {9'h000, locked, cfg}, 16'h004D);
        wr(ADDR_LINE1, 16'h4000);
        check("locked cfg", {9'h000, locked, cfg}, 16'h004D);
        check("ecc flags", {14'h0000, ecc_fix, ecc_bad}, 16'h0000);
        wrap_up();
    end
endmodule // smcp_config_port_test
